// >>> remappable_pin_select_bench.sv
// Register and routing tests for the remappable pin select block
`default_nettype none
module remappable_pin_select_bench import rps_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic sys_rst;
  rps_axi_req_t rq;
  rps_axi_rsp_t rs, rs_s;
  rps_periph_in_t pin_in;
  logic [7:0] pout, pout_s;
  logic [63:0] pins, funcs;
  logic [5:0] fsel, psel;
  int n_errors = 0, compares = 0;
  logic [15:0] rv[9] = '{16'h3f3f, 16'h003f, 16'h3f3f, 16'h3f3f, 16'h003f,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] wv[5] = '{16'h0104, 16'h0007, 16'h0a0d, 16'h1013, 16'h0016};
  always #50 clk = ~clk;
  rps_top dut (.clk(clk), .sys_rst(sys_rst), .s_axi_req(rq), .s_axi_rsp(rs),
    .remappable_pin(pins), .func_out(funcs), .periph_in(pin_in), .pin_out(pout));
  // Smallest package variant on the same bus; only pin 5 storage differs
  rps_top #(.SMALL_PACKAGE(1'b1)) dut_small (.clk(clk), .sys_rst(sys_rst), .s_axi_req(rq),
    .s_axi_rsp(rs_s), .remappable_pin(pins), .func_out(funcs), .periph_in(),
    .pin_out(pout_s));
  rps_far_model far (.fsel(fsel), .psel(psel), .pins(pins), .funcs(funcs));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ra, rw, b;
    logic [1:0] r;
    rq.awaddr <= a;
    rq.wdata <= {16'hffff, d};
    rq.awvalid <= 1'h1;
    rq.wvalid <= 1'h1;
    forever begin
      @(negedge clk);
      ra = rs.awready;
      rw = rs.wready;
      b = rs.bvalid;
      r = rs.bresp;
      @(posedge clk);
      if (ra) rq.awvalid <= 1'h0;
      if (rw) rq.wvalid <= 1'h0;
      if (b) begin
        chk("bresp", 32'(er), 32'(r));
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    logic ra, v;
    logic [31:0] d;
    logic [31:0] ds;
    logic [1:0] r;
    rq.araddr <= a;
    rq.arvalid <= 1'h1;
    forever begin
      @(negedge clk);
      ra = rs.arready;
      v = rs.rvalid;
      d = rs.rdata;
      ds = rs_s.rdata;
      r = rs.rresp;
      @(posedge clk);
      if (ra) rq.arvalid <= 1'h0;
      if (v) begin
        chk("rdata", 32'(e), d);
        chk("rdata_small", 32'((a == RPS_OFS_OUT45) ? e & RPS_MASK_ONE : e), ds);
        chk("rresp", 32'(er), 32'(r));
        break;
      end
    end
  endtask
  task automatic results();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    // Readies held high throughout, legal for the master
    rq = '0;
    rq.wstrb = 4'hf;
    rq.bready = 1'h1;
    rq.rready = 1'h1;
    sys_rst = 1'h1;
    fsel = 6'h0;
    psel = 6'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd(8'(4 * i), rv[i], RPS_RESP_OKAY);
    $display("reset values done");
    for (int i = 0; i < 9; i++) begin
      wr(8'(4 * i), 16'hffff, RPS_RESP_OKAY);
      rd(8'(4 * i), (i == 1 || i == 4) ? 16'h003f : 16'h3f3f, RPS_RESP_OKAY);
    end
    $display("write mask done");
    for (int i = 0; i < 5; i++) wr(8'(4 * i), wv[i] | 16'hc0c0, RPS_RESP_OKAY);
    // Field k selects pin 3k+1; only one input may see the high pin
    for (int k = 0; k < 8; k++) begin
      psel <= 6'(3 * k + 1);
      repeat (5) @(posedge clk);
      chk("periph_in", 32'(8'h80 >> k), 32'(pin_in));
    end
    $display("input routing done");
    for (int i = 0; i < 4; i++)
      wr(8'h14 + 8'(4 * i), {8'(11 + 2 * i), 8'(10 + 2 * i)}, RPS_RESP_OKAY);
    for (int p = 0; p < 8; p++) begin
      fsel <= 6'(10 + p);
      repeat (2) @(posedge clk);
      chk("pin_out", 32'(8'h1 << p), 32'(pout));
      chk("pin_out_small", 32'((8'h1 << p) & ~(8'h1 << RPS_SMALL_PIN)), 32'(pout_s));
    end
    $display("output mapping done");
    wr(8'h24, 16'h1234, RPS_RESP_SLVERR);
    rd(8'h24, 16'h0, RPS_RESP_SLVERR);
    rd(8'h14, 16'h0b0a, RPS_RESP_OKAY);
    $display("unmapped access done");
    results();
  end
endmodule
`default_nettype wire

// >>> rps_far_model.sv
// Far side: one-hot pin levels and peripheral output functions
`default_nettype none
module rps_far_model import rps_pkg::*; (
  input wire logic [5:0] fsel,
  input wire logic [5:0] psel,
  output logic [63:0] pins,
  output logic [RPS_FUNCS-1:0] funcs
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-hot so a wrong route shows as a zero, never a lucky match
  assign pins = 64'h1 << psel;
  assign funcs = 64'h1 << fsel;
endmodule
`default_nettype wire

// >>> rps_pkg.sv
// Constants and carrier types for the remappable pin select block
// Behaviour
// - Second SPI clock from field bits 13:8, data from bits 5:0.
// - Second SPI slave select from bits 5:0; bits 15:6 unimplemented.
// - Fourth UART clear-to-send from bits 13:8, receive from bits 5:0.
// - Third SPI clock from field bits 13:8, data from bits 5:0.
// - Third SPI slave select from bits 5:0; upper ten bits unimplemented.
// - Input select fields are six bits naming the feeding pin.
// - Input select bits are read/write and reset to all ones.
// - Output mapping bits are read/write and reset to zero.
// - Unimplemented bits read zero and ignore writes.
// - Output field value n drives the pin with function n.
// - Output registers hold even pin in 5:0, odd pin in 13:8.
// - Small package variant: pin 5 field unimplemented, reads zero.
`default_nettype none
package rps_pkg;
  localparam int RPS_ADDR_W = 8;
  localparam int RPS_NREG = 9;
  localparam int RPS_IN_PINS = 64;
  localparam int RPS_OUT_PINS = 8;
  localparam int RPS_FUNCS = 64;
  localparam int RPS_FIELD_W = 6;
  localparam int RPS_LO_POS = 0;
  localparam int RPS_HI_POS = 8;
  localparam int RPS_SMALL_PIN = 5;
  localparam int RPS_IDX_SPI2_CD = 0;
  localparam int RPS_IDX_SPI2_SS = 1;
  localparam int RPS_IDX_UART4 = 2;
  localparam int RPS_IDX_SPI3_CD = 3;
  localparam int RPS_IDX_SPI3_SS = 4;
  localparam int RPS_IDX_OUT0 = 5;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_SPI2_CD = 8'h00;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_SPI2_SS = 8'h04;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_UART4 = 8'h08;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_SPI3_CD = 8'h0c;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_SPI3_SS = 8'h10;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_OUT01 = 8'h14;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_OUT23 = 8'h18;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_OUT45 = 8'h1c;
  localparam logic [RPS_ADDR_W-1:0] RPS_OFS_OUT67 = 8'h20;
  localparam logic [15:0] RPS_MASK_TWO = 16'h3f3f;
  localparam logic [15:0] RPS_MASK_ONE = 16'h003f;
  localparam logic [15:0] RPS_RST_IN_TWO = 16'h3f3f;
  localparam logic [15:0] RPS_RST_IN_ONE = 16'h003f;
  localparam logic [15:0] RPS_RST_OUT = 16'h0000;
  localparam logic [1:0] RPS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RPS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [RPS_ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [RPS_ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } rps_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rps_axi_rsp_t;

  typedef struct packed {
    logic second_spi_clock_input;
    logic second_spi_data_input;
    logic second_spi_slave_select_input;
    logic fourth_uart_clear_to_send;
    logic fourth_uart_receive;
    logic third_spi_clock_input;
    logic third_spi_data_input;
    logic third_spi_slave_select_input;
  } rps_periph_in_t;
endpackage
`default_nettype wire

// >>> rps_sva.sv
// Bus and read-back checker for the remappable pin select block
`default_nettype none
module rps_sva import rps_pkg::*; #(
  parameter int IN_PINS = RPS_IN_PINS,
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rps_axi_req_t s_axi_req,
  input wire rps_axi_rsp_t s_axi_rsp,
  input wire logic [IN_PINS-1:0] remappable_pin,
  input wire logic [RPS_FUNCS-1:0] func_out,
  input wire rps_periph_in_t periph_in,
  input wire logic [RPS_OUT_PINS-1:0] pin_out
);
  rps_axi_req_t q;
  rps_axi_rsp_t p;
  assign q = s_axi_req;
  assign p = s_axi_rsp;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_hi0; p.rvalid |-> p.rdata[31:16] == 16'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("rdata upper half not zero");
  property p_gap;
    p.rvalid && p.rresp == RPS_RESP_OKAY |-> p.rdata[15:14] == 2'h0 && p.rdata[7:6] == 2'h0;
  endproperty
  a_gap: assert property (p_gap) else $error("unimplemented bits read nonzero");
  // Both halves taken, held next edge, register and response commit the edge after
  property p_wans; q.awvalid && p.awready && q.wvalid && p.wready |-> ##2 p.bvalid; endproperty
  a_wans: assert property (p_wans) else $error("write response late");
  property p_rans; q.arvalid && p.arready |=> p.rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read response late");
  property p_bdrop; p.bvalid && q.bready |=> !p.bvalid; endproperty
  a_bdrop: assert property (p_bdrop) else $error("write response repeated");
  property p_rdrop; p.rvalid && q.rready |=> !p.rvalid; endproperty
  a_rdrop: assert property (p_rdrop) else $error("read response repeated");
  property p_bbusy; p.bvalid |-> !p.awready && !p.wready; endproperty
  a_bbusy: assert property (p_bbusy) else $error("write accepted during response");
  property p_slv;
    q.arvalid && p.arready && q.araddr > 8'h20 |=>
      p.rresp == RPS_RESP_SLVERR && p.rdata == 32'h0;
  endproperty
  a_slv: assert property (p_slv) else $error("unmapped read not refused");
  // No write committed and functions still: pin drive must hold
  property p_fmap;
    !$past(sys_rst) && $stable(func_out) && !p.bvalid |=> $stable(pin_out);
  endproperty
  a_fmap: assert property (p_fmap) else $error("pin drive moved without cause");
  // Sync path is two flops deep, so the pin must hold across that span
  property p_pmap;
    !$past(sys_rst, 3) && $stable(remappable_pin) ##2 !p.bvalid |=> $stable(periph_in);
  endproperty
  a_pmap: assert property (p_pmap) else $error("peripheral input moved without cause");
  c_wr: cover property (p.bvalid && q.bready);
  c_rd: cover property (p.rvalid && q.rready);
  c_err: cover property (p.bvalid && p.bresp == RPS_RESP_SLVERR);
endmodule
bind rps_top rps_sva #(.IN_PINS(IN_PINS), .SMALL_PACKAGE(SMALL_PACKAGE)) u_sva (
  .clk(clk), .sys_rst(sys_rst), .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp),
  .remappable_pin(remappable_pin), .func_out(func_out), .periph_in(periph_in),
  .pin_out(pin_out));
`default_nettype wire

// >>> rps_top.sv
// Remappable pin select: register file, input routing and output mapping
`default_nettype none
module rps_top import rps_pkg::*; #(
  parameter int IN_PINS = RPS_IN_PINS,
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rps_axi_req_t s_axi_req,
  output rps_axi_rsp_t s_axi_rsp,
  input wire logic [IN_PINS-1:0] remappable_pin,
  input wire logic [RPS_FUNCS-1:0] func_out,
  output rps_periph_in_t periph_in,
  output logic [RPS_OUT_PINS-1:0] pin_out
);

  typedef struct packed {
    logic [IN_PINS-1:0] sync1;
    logic [IN_PINS-1:0] sync2;
    logic [RPS_NREG-1:0][15:0] regs;
    rps_periph_in_t pin_in;
    logic [RPS_OUT_PINS-1:0] pin_drv;
    logic aw_got;
    logic w_got;
    logic [RPS_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rps_state_t;

  // Highest index first: output maps, then the five input selects
  localparam logic [RPS_NREG-1:0][15:0] RST_REGS = {
    RPS_RST_OUT, RPS_RST_OUT, RPS_RST_OUT, RPS_RST_OUT,
    RPS_RST_IN_ONE, RPS_RST_IN_TWO, RPS_RST_IN_TWO,
    RPS_RST_IN_ONE, RPS_RST_IN_TWO
  };

  localparam rps_state_t RST_STATE = '{
    sync1: '0,
    sync2: '0,
    regs: RST_REGS,
    pin_in: '0,
    pin_drv: '0,
    aw_got: 1'b0,
    w_got: 1'b0,
    awaddr: '0,
    wdata: '0,
    wstrb: '0,
    awready: 1'b0,
    wready: 1'b0,
    bvalid: 1'b0,
    bresp: RPS_RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rdata: '0,
    rresp: RPS_RESP_OKAY
  };

  rps_state_t state_ff;
  rps_state_t nxt_state;

  // Map a byte address to a register index; the return value says if mapped
  function automatic logic decode(
    input logic [RPS_ADDR_W-1:0] addr,
    output logic [3:0] idx
  );
    logic hit;
    hit = 1'b1;
    case (addr)
      RPS_OFS_SPI2_CD: idx = 4'(RPS_IDX_SPI2_CD);
      RPS_OFS_SPI2_SS: idx = 4'(RPS_IDX_SPI2_SS);
      RPS_OFS_UART4: idx = 4'(RPS_IDX_UART4);
      RPS_OFS_SPI3_CD: idx = 4'(RPS_IDX_SPI3_CD);
      RPS_OFS_SPI3_SS: idx = 4'(RPS_IDX_SPI3_SS);
      RPS_OFS_OUT01: idx = 4'(RPS_IDX_OUT0);
      RPS_OFS_OUT23: idx = 4'(RPS_IDX_OUT0 + 1);
      RPS_OFS_OUT45: idx = 4'(RPS_IDX_OUT0 + 2);
      RPS_OFS_OUT67: idx = 4'(RPS_IDX_OUT0 + 3);
      default: begin
        idx = 4'h0;
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Writable bits of each register; everything else stays zero
  function automatic logic [15:0] wmask(input logic [3:0] idx);
    logic [15:0] m;
    m = RPS_MASK_TWO;
    if (idx == 4'(RPS_IDX_SPI2_SS) || idx == 4'(RPS_IDX_SPI3_SS)) begin
      m = RPS_MASK_ONE;
    end
    // Pin 5 has no storage in the small package, so it always reads zero
    if (SMALL_PACKAGE && idx == 4'(RPS_IDX_OUT0 + RPS_SMALL_PIN / 2)) begin
      m = RPS_MASK_ONE;
    end
    return m;
  endfunction

  // Pick a synchronised pin; selects past the last pin read as zero
  function automatic logic pick(
    input logic [IN_PINS-1:0] pins,
    input logic [RPS_FIELD_W-1:0] sel
  );
    logic v;
    v = 1'b0;
    if (32'(sel) < IN_PINS) begin
      v = pins[sel];
    end
    return v;
  endfunction

  function automatic logic [RPS_FIELD_W-1:0] lo_field(input logic [15:0] r);
    return r[RPS_LO_POS +: RPS_FIELD_W];
  endfunction

  function automatic logic [RPS_FIELD_W-1:0] hi_field(input logic [15:0] r);
    return r[RPS_HI_POS +: RPS_FIELD_W];
  endfunction

  always_comb begin
    logic [3:0] widx;
    logic [3:0] ridx;
    logic whit;
    logic rhit;
    logic [15:0] bmask;
    logic [15:0] m;
    logic [RPS_FIELD_W-1:0] osel;
    widx = 4'h0;
    ridx = 4'h0;
    whit = 1'b0;
    rhit = 1'b0;
    bmask = 16'h0000;
    m = 16'h0000;
    osel = '0;
    nxt_state = state_ff;

    // Pins come from outside; the first stage feeds only the second
    nxt_state.sync1 = remappable_pin;
    nxt_state.sync2 = state_ff.sync1;

    // Write address and data are taken in either order
    if (s_axi_req.awvalid && state_ff.awready) begin
      nxt_state.aw_got = 1'b1;
      nxt_state.awaddr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && state_ff.wready) begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = s_axi_req.wdata;
      nxt_state.wstrb = s_axi_req.wstrb;
    end

    // Both halves held: commit the strobed bytes of the register in one cycle
    if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid) begin
      whit = decode(state_ff.awaddr, widx);
      if (whit) begin
        bmask = {{8{state_ff.wstrb[1]}}, {8{state_ff.wstrb[0]}}};
        m = wmask(widx) & bmask;
        nxt_state.regs[widx] =
          (state_ff.regs[widx] & ~m) | (state_ff.wdata[15:0] & m);
      end
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = whit ? RPS_RESP_OKAY : RPS_RESP_SLVERR;
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
    end
    if (state_ff.bvalid && s_axi_req.bready) begin
      nxt_state.bvalid = 1'b0;
    end
    // Ready drops while a write is pending so only one is in flight
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid
      && !(state_ff.aw_got && state_ff.w_got);
    nxt_state.wready = !nxt_state.w_got && !nxt_state.bvalid
      && !(state_ff.aw_got && state_ff.w_got);

    // Read: upper sixteen bits and unimplemented bits are zero
    if (s_axi_req.arvalid && state_ff.arready) begin
      rhit = decode(s_axi_req.araddr, ridx);
      nxt_state.rvalid = 1'b1;
      nxt_state.rdata = rhit ? {16'h0000, state_ff.regs[ridx]} : 32'h0000_0000;
      nxt_state.rresp = rhit ? RPS_RESP_OKAY : RPS_RESP_SLVERR;
    end
    if (state_ff.rvalid && s_axi_req.rready) begin
      nxt_state.rvalid = 1'b0;
    end
    nxt_state.arready = !nxt_state.rvalid;

    // Input routing reads the stored fields, so a write acts a cycle later
    nxt_state.pin_in.second_spi_clock_input =
      pick(state_ff.sync2, hi_field(state_ff.regs[RPS_IDX_SPI2_CD]));
    nxt_state.pin_in.second_spi_data_input =
      pick(state_ff.sync2, lo_field(state_ff.regs[RPS_IDX_SPI2_CD]));
    nxt_state.pin_in.second_spi_slave_select_input =
      pick(state_ff.sync2, lo_field(state_ff.regs[RPS_IDX_SPI2_SS]));
    nxt_state.pin_in.fourth_uart_clear_to_send =
      pick(state_ff.sync2, hi_field(state_ff.regs[RPS_IDX_UART4]));
    nxt_state.pin_in.fourth_uart_receive =
      pick(state_ff.sync2, lo_field(state_ff.regs[RPS_IDX_UART4]));
    nxt_state.pin_in.third_spi_clock_input =
      pick(state_ff.sync2, hi_field(state_ff.regs[RPS_IDX_SPI3_CD]));
    nxt_state.pin_in.third_spi_data_input =
      pick(state_ff.sync2, lo_field(state_ff.regs[RPS_IDX_SPI3_CD]));
    nxt_state.pin_in.third_spi_slave_select_input =
      pick(state_ff.sync2, lo_field(state_ff.regs[RPS_IDX_SPI3_SS]));

    // Output mapping: even pin low field, odd pin high field
    for (int p = 0; p < RPS_OUT_PINS; p++) begin
      if (p % 2 == 0) begin
        osel = lo_field(state_ff.regs[RPS_IDX_OUT0 + p / 2]);
      end else begin
        osel = hi_field(state_ff.regs[RPS_IDX_OUT0 + p / 2]);
      end
      nxt_state.pin_drv[p] = func_out[osel];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= RST_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign s_axi_rsp.awready = state_ff.awready;
  assign s_axi_rsp.wready = state_ff.wready;
  assign s_axi_rsp.bvalid = state_ff.bvalid;
  assign s_axi_rsp.bresp = state_ff.bresp;
  assign s_axi_rsp.arready = state_ff.arready;
  assign s_axi_rsp.rvalid = state_ff.rvalid;
  assign s_axi_rsp.rdata = state_ff.rdata;
  assign s_axi_rsp.rresp = state_ff.rresp;
  assign periph_in = state_ff.pin_in;
  assign pin_out = state_ff.pin_drv;

endmodule
`default_nettype wire
